//--- test/bsc_props.sv
// Purpose: Assertions on bias routing and monitor decode outputs
// Assumes: Only the lane 0 strobe decides whether a write lands
// Notes:   Write address and data captured at their handshakes
`timescale 1ns/1ps
`include "bsc_defines.vh"

module bsc_props (
    input logic                   CLOCK_IN,
    input logic                   RESET_N_IN,
    input logic [`BSC_ADDR_W-1:0] S_AXI_AWADDR_IN,
    input logic                   S_AXI_AWVALID_IN,
    input logic                   S_AXI_AWREADY_OUT,
    input logic [31:0]            S_AXI_WDATA_IN,
    input logic [3:0]             S_AXI_WSTRB_IN,
    input logic                   S_AXI_WVALID_IN,
    input logic                   S_AXI_WREADY_OUT,
    input logic [1:0]             S_AXI_BRESP_OUT,
    input logic                   S_AXI_BVALID_OUT,
    input logic                   S_AXI_BREADY_IN,
    input logic                   S_AXI_ARVALID_IN,
    input logic                   S_AXI_ARREADY_OUT,
    input logic                   S_AXI_RVALID_OUT,
    input logic                   BIAS_ENABLE_OUT,
    input logic                   BIAS_LEVEL_SELECT_OUT,
    input logic                   BIAS_TO_COMMON_INPUT_OUT,
    input logic [5:0]             BIAS_TO_INPUT_OUT,
    input logic                   INPUTS_SHORTED_MID_OUT,
    input logic                   TEMP_SENSOR_OUT,
    input logic                   AVDD_MONITOR_OUT,
    input logic                   DVDD_MONITOR_OUT,
    input logic                   BURNOUT_ENABLE_OUT,
    input logic [1:0]             BURNOUT_LEVEL_OUT,
    input logic                   FORCE_UNITY_GAIN_OUT,
    input logic                   MUX_OPEN_OUT,
    input logic [4:0]             CAL_SAMPLES_OUT,
    input logic                   SPI_TIMEOUT_ENABLE_OUT,
    input logic                   CHECK_BYTE_APPEND_OUT,
    input logic                   STATUS_BYTE_PREPEND_OUT
);
    logic [11:0] aw_q;
    logic [7:0]  wd_q;
    logic        ws_q;
    wire  [2:0]  m = wd_q[7:5];
    wire  [4:0]  cal_exp = (wd_q[4:3] == 2'h0) ? 5'h01 : 5'h02 << wd_q[4:3];
    wire  [4:0]  mon_exp = {m == 3'h1, m == 3'h2, m == 3'h3, m == 3'h4, m >= 3'h5};
    wire  [1:0]  bo_exp = (m >= 3'h5) ? 2'(m - 3'h5) : 2'h0;
    wire         b_ok = S_AXI_BVALID_OUT && S_AXI_BREADY_IN && S_AXI_BRESP_OUT == 2'h0 && ws_q;
    wire         bias_skip = S_AXI_BVALID_OUT && S_AXI_BREADY_IN && !ws_q &&
                             aw_q == {2'h0, `BSC_IDX_BIAS, 2'h0};
    wire         bias_wr = b_ok && aw_q == {2'h0, `BSC_IDX_BIAS, 2'h0};
    wire         sys_wr = b_ok && aw_q == {2'h0, `BSC_IDX_SYSCTL, 2'h0};

    // ==========================================================================
    // Capture, so a later write cannot blur which value is checked
    always_ff @(posedge CLOCK_IN or negedge RESET_N_IN) begin
        if (!RESET_N_IN) begin
            aw_q <= 12'h000;
            wd_q <= 8'h00;
            ws_q <= 1'b0;
        end else begin
            if (S_AXI_AWVALID_IN && S_AXI_AWREADY_OUT) aw_q <= S_AXI_AWADDR_IN;
            if (S_AXI_WVALID_IN && S_AXI_WREADY_OUT) begin
                wd_q <= S_AXI_WDATA_IN[7:0];
                ws_q <= S_AXI_WSTRB_IN[0];
            end
        end
    end

    default clocking cb @(posedge CLOCK_IN); endclocking
    default disable iff (!RESET_N_IN);

    // ==========================================================================
    // Assertions
    bias_enable_a:
        assert property (BIAS_ENABLE_OUT == (BIAS_TO_COMMON_INPUT_OUT || |BIAS_TO_INPUT_OUT))
        else $error("bias enable does not follow connections");
    bias_write_a:
        assert property (bias_wr |=> {BIAS_LEVEL_SELECT_OUT, BIAS_TO_COMMON_INPUT_OUT,
            BIAS_TO_INPUT_OUT} == $past(wd_q)) else $error("bias outputs wrong after write");
    sys_fields_a:
        assert property (sys_wr |=> CAL_SAMPLES_OUT == $past(cal_exp) && {SPI_TIMEOUT_ENABLE_OUT,
            CHECK_BYTE_APPEND_OUT, STATUS_BYTE_PREPEND_OUT} == $past(wd_q[2:0]))
        else $error("system control outputs wrong after write");
    mon_decode_a:
        assert property (sys_wr |=> {INPUTS_SHORTED_MID_OUT, TEMP_SENSOR_OUT, AVDD_MONITOR_OUT,
            DVDD_MONITOR_OUT, BURNOUT_ENABLE_OUT} == $past(mon_exp)
            && BURNOUT_LEVEL_OUT == $past(bo_exp)) else $error("monitor decode wrong");
    unity_gain_a:
        assert property (FORCE_UNITY_GAIN_OUT == (AVDD_MONITOR_OUT || DVDD_MONITOR_OUT))
        else $error("unity gain wrong");
    mux_open_a:
        assert property (MUX_OPEN_OUT == (INPUTS_SHORTED_MID_OUT || TEMP_SENSOR_OUT
            || AVDD_MONITOR_OUT || DVDD_MONITOR_OUT)) else $error("mux open wrong");
    reset_vals_a:
        assert property ($rose(RESET_N_IN) |-> CAL_SAMPLES_OUT == 5'h08 && !BIAS_ENABLE_OUT
            && !BIAS_LEVEL_SELECT_OUT) else $error("outputs wrong after reset");
    read_answer_a:
        assert property (S_AXI_ARVALID_IN && S_AXI_ARREADY_OUT |=> S_AXI_RVALID_OUT)
        else $error("read not answered next cycle");
    strobe_skip_a:
        assert property (bias_skip |=> $stable({BIAS_LEVEL_SELECT_OUT, BIAS_TO_COMMON_INPUT_OUT,
            BIAS_TO_INPUT_OUT})) else $error("bias changed by write without lane 0 strobe");
    cover property (bias_skip);
    cover property (bias_wr);
    cover property (sys_wr);
    cover property (BURNOUT_ENABLE_OUT && BURNOUT_LEVEL_OUT == 2'h2);
endmodule // bsc_props

bind bsc_top bsc_props u_props (.*);

//--- test/test_bias_and_sysmon_config.sv
// Purpose: Self-checking bench for the bias and monitor register pair
// Assumes: Bus master keeps one write or read in flight
// Notes:   Decode outputs are also watched by the bound checker
`timescale 1ns/1ps
`include "bsc_defines.vh"

module test_bias_and_sysmon_config;
    logic        CLOCK_IN, RESET_N_IN, S_AXI_AWVALID_IN, S_AXI_WVALID_IN, S_AXI_BREADY_IN;
    logic        S_AXI_ARVALID_IN, S_AXI_RREADY_IN;
    logic [11:0] S_AXI_AWADDR_IN, S_AXI_ARADDR_IN;
    logic [31:0] S_AXI_WDATA_IN;
    logic [3:0]  S_AXI_WSTRB_IN = 4'hf;
    logic [2:0]  S_AXI_AWPROT_IN = 3'h0, S_AXI_ARPROT_IN = 3'h0;
    logic [1:0]  AMPLIFIER_ENABLE_FIELD_IN;
    wire         S_AXI_AWREADY_OUT, S_AXI_WREADY_OUT, S_AXI_BVALID_OUT, S_AXI_ARREADY_OUT;
    wire         S_AXI_RVALID_OUT, BIAS_ENABLE_OUT, BIAS_LEVEL_SELECT_OUT, BIAS_TO_COMMON_INPUT_OUT;
    wire         INPUTS_SHORTED_MID_OUT, TEMP_SENSOR_OUT, AVDD_MONITOR_OUT, DVDD_MONITOR_OUT;
    wire         BURNOUT_ENABLE_OUT, FORCE_UNITY_GAIN_OUT, MUX_OPEN_OUT, SPI_TIMEOUT_ENABLE_OUT;
    wire         CHECK_BYTE_APPEND_OUT, STATUS_BYTE_PREPEND_OUT;
    wire [1:0]   S_AXI_BRESP_OUT, S_AXI_RRESP_OUT, BURNOUT_LEVEL_OUT;
    wire [31:0]  S_AXI_RDATA_OUT;
    wire [5:0]   BIAS_TO_INPUT_OUT;
    wire [4:0]   CAL_SAMPLES_OUT;
    int          failures = 0;
    int          samples_checked = 0;
    logic [1:0]  wr_q[$];
    logic [33:0] rd_q[$];
    logic [5:0]  lvl_q[$];
    logic        look = 1'b0;
    localparam logic [11:0] A_BIAS = {2'h0, `BSC_IDX_BIAS, 2'h0};
    localparam logic [11:0] A_SYS  = {2'h0, `BSC_IDX_SYSCTL, 2'h0};
    localparam logic [11:0] A_STAT = {2'h0, `BSC_IDX_STATUS, 2'h0};

    bsc_top u_dut (.*);

    // ==========================================================================
    // Checking and closing
    task automatic check_val(input logic [33:0] got, input logic [33:0] exp, input string what);
        samples_checked++;
        if (got !== exp) begin
            failures++;
            $display("CHECK FAILED %0t %s got %h exp %h", $time, what, got, exp);
        end
    endtask
    task automatic check_resp(input logic [1:0] got, input logic [1:0] exp);
        check_val({32'h0, got}, {32'h0, exp}, "write response");
    endtask
    task automatic check_read(input logic [33:0] got, input logic [33:0] exp);
        check_val(got, exp, "read response and data");
    endtask
    task automatic check_level(input logic [5:0] got, input logic [5:0] exp);
        check_val({28'h0, got}, {28'h0, exp}, "calibration count and bias enable");
    endtask
    // Monitor compares the outputs at the edge after the note is made
    task automatic note_level(input logic [5:0] e);
        lvl_q.push_back(e);
        look <= 1'b1;
        @(posedge CLOCK_IN);
        look <= 1'b0;
    endtask
    task automatic tally_and_finish;
        $display("failures %0d samples_checked %0d", failures, samples_checked);
        if (failures == 0 && samples_checked > 0)
            $display("TEST PASSED");
        else
            $display("TEST FAILED");
        $finish;
    endtask

    // ==========================================================================
    // Bus tasks: handshakes judged at the negedge, where readys have settled
    task automatic axi_write(input logic [11:0] a, input logic [7:0] d, input logic [1:0] r);
        logic aw, w, b;
        wr_q.push_back(r);
        S_AXI_AWADDR_IN <= a;
        S_AXI_WDATA_IN <= {24'h0, d};
        S_AXI_AWVALID_IN <= 1'b1;
        S_AXI_WVALID_IN <= 1'b1;
        S_AXI_BREADY_IN <= 1'b1;
        b = 1'b0;
        while (!b) begin
            @(negedge CLOCK_IN);
            aw = S_AXI_AWVALID_IN && S_AXI_AWREADY_OUT;
            w = S_AXI_WVALID_IN && S_AXI_WREADY_OUT;
            b = S_AXI_BVALID_OUT;
            @(posedge CLOCK_IN);
            if (aw) S_AXI_AWVALID_IN <= 1'b0;
            if (w) S_AXI_WVALID_IN <= 1'b0;
        end
        S_AXI_BREADY_IN <= 1'b0;
        @(posedge CLOCK_IN);
    endtask
    task automatic axi_read(input logic [11:0] a, input logic [1:0] r, input logic [31:0] d);
        logic ar, rv;
        rd_q.push_back({r, d});
        S_AXI_ARADDR_IN <= a;
        S_AXI_ARVALID_IN <= 1'b1;
        S_AXI_RREADY_IN <= 1'b1;
        rv = 1'b0;
        while (!rv) begin
            @(negedge CLOCK_IN);
            ar = S_AXI_ARVALID_IN && S_AXI_ARREADY_OUT;
            rv = S_AXI_RVALID_OUT;
            @(posedge CLOCK_IN);
            if (ar) S_AXI_ARVALID_IN <= 1'b0;
        end
        S_AXI_RREADY_IN <= 1'b0;
        @(posedge CLOCK_IN);
    endtask

    always @(posedge CLOCK_IN) begin
        if (S_AXI_BVALID_OUT && S_AXI_BREADY_IN && wr_q.size() > 0)
            check_resp(S_AXI_BRESP_OUT, wr_q.pop_front());
        if (S_AXI_RVALID_OUT && S_AXI_RREADY_IN && rd_q.size() > 0)
            check_read({S_AXI_RRESP_OUT, S_AXI_RDATA_OUT}, rd_q.pop_front());
        if (look && lvl_q.size() > 0)
            check_level({CAL_SAMPLES_OUT, BIAS_ENABLE_OUT}, lvl_q.pop_front());
    end

    initial begin
        CLOCK_IN = 1'b0;
        forever #5 CLOCK_IN = ~CLOCK_IN;
    end
    initial begin
        #100000;
        failures++;
        tally_and_finish;
    end

    // ==========================================================================
    // Main sequence
    initial begin
        logic [7:0] v, bv;
        logic [4:0] c;
        void'($urandom(32'h46679c47));
        RESET_N_IN = 1'b0;
        {S_AXI_AWVALID_IN, S_AXI_WVALID_IN, S_AXI_BREADY_IN} = 3'h0;
        {S_AXI_ARVALID_IN, S_AXI_RREADY_IN} = 2'h0;
        {S_AXI_AWADDR_IN, S_AXI_ARADDR_IN} = 24'h0;
        S_AXI_WDATA_IN = 32'h0;
        AMPLIFIER_ENABLE_FIELD_IN = 2'h0;
        repeat (2) @(posedge CLOCK_IN);
        RESET_N_IN <= 1'b1;
        @(posedge CLOCK_IN);
        note_level({5'h08, 1'b0});
        axi_read(A_BIAS, 2'h0, 32'h00);
        axi_read(A_SYS, 2'h0, 32'h10);
        for (int i = 0; i < 8; i++) begin
            bv = (i == 0) ? 8'h80 : (i == 1) ? 8'h40 : (i == 2) ? 8'hff : 8'($urandom);
            axi_write(A_BIAS, bv, 2'h0);
            axi_read(A_BIAS, 2'h0, {24'h0, bv});
            note_level({5'h08, |bv[6:0]});
        end
        for (int m = 0; m < 8; m++) begin
            v = {3'(m), 2'(m), 3'($urandom)};
            AMPLIFIER_ENABLE_FIELD_IN <= 2'($urandom);
            axi_write(A_SYS, v, 2'h0);
            axi_read(A_SYS, 2'h0, {24'h0, v});
            c = (m % 4 == 0) ? 5'h01 : (m % 4 == 1) ? 5'h04 : (m % 4 == 2) ? 5'h08 : 5'h10;
            note_level({c, |bv[6:0]});
            axi_read(A_STAT, 2'h0, {31'h0, m == 2 && AMPLIFIER_ENABLE_FIELD_IN != 2'h1});
        end
        // Refused accesses must leave the registers alone
        axi_read(12'h100, 2'h2, 32'h0);
        axi_write(A_BIAS + 12'h1, 8'h5a, 2'h2);
        axi_write(12'h028, 8'h5a, 2'h2);
        // Write without the lane 0 strobe is answered but must not land
        S_AXI_WSTRB_IN <= 4'he;
        axi_write(A_BIAS, ~bv, 2'h0);
        S_AXI_WSTRB_IN <= 4'hf;
        axi_read(A_BIAS, 2'h0, {24'h0, bv});
        RESET_N_IN <= 1'b0;
        repeat (2) @(posedge CLOCK_IN);
        RESET_N_IN <= 1'b1;
        @(posedge CLOCK_IN);
        axi_read(A_BIAS, 2'h0, 32'h00);
        axi_read(A_SYS, 2'h0, 32'h10);
        tally_and_finish;
    end
endmodule // test_bias_and_sysmon_config

//--- verilog/bsc_defines.vh
// Purpose: Offsets, field positions and reset values of the bias and monitor registers
// Assumes: 32-bit AXI4-Lite slave, one register per aligned word
// Notes:   Offsets are register indexes; byte address is four times the index
`ifndef BSC_DEFINES_VH
`define BSC_DEFINES_VH

// ==========================================================================
// Register map
`define BSC_IDX_BIAS        8'h08
`define BSC_IDX_SYSCTL      8'h09
`define BSC_IDX_STATUS      8'h0f
`define BSC_ADDR_W          12

// ==========================================================================
// Reset values
`define BSC_RST_BIAS        8'h00
`define BSC_RST_SYSCTL      8'h10
`define BSC_RST_CALCNT      5'h08

// ==========================================================================
// Bias register fields
`define BSC_BIAS_LEVEL_BIT  7
`define BSC_BIAS_COM_BIT    6
`define BSC_BIAS_IN_HI      5
`define BSC_BIAS_IN_LO      0

// ==========================================================================
// System control fields
`define BSC_MON_HI          7
`define BSC_MON_LO          5
`define BSC_CAL_HI          4
`define BSC_CAL_LO          3
`define BSC_TMO_BIT         2
`define BSC_CRC_BIT         1
`define BSC_STAT_BIT        0

// ==========================================================================
// Monitor codes
`define BSC_MON_OFF         3'h0
`define BSC_MON_MIDSUP      3'h1
`define BSC_MON_TEMP        3'h2
`define BSC_MON_AVDD        3'h3
`define BSC_MON_DVDD        3'h4
`define BSC_MON_BO_0U2      3'h5
`define BSC_MON_BO_1U       3'h6
`define BSC_MON_BO_10U      3'h7

// ==========================================================================
// Amplifier enable code needed by the temperature mode
`define BSC_AMP_ON          2'h1

// ==========================================================================
// AXI response codes
`define BSC_RESP_OKAY       2'h0
`define BSC_RESP_SLVERR     2'h2

`endif

//--- verilog/bsc_mon_decode.v
// Purpose: Decode of the monitor field into analog control strobes
// Assumes: Inputs are register outputs on the same clock
// Notes:   Outputs are registered
`timescale 1ns/1ps
`include "bsc_defines.vh"

module bsc_mon_decode (
    input  wire       clk_in,
    input  wire       reset_n_in,
    input  wire [2:0] monitor_select_in,
    input  wire [1:0] calibration_average_count_in,
    input  wire [1:0] amplifier_enable_field_in,
    output reg        inputs_shorted_mid_out,
    output reg        temp_sensor_out,
    output reg        avdd_monitor_out,
    output reg        dvdd_monitor_out,
    output reg  [1:0] burnout_level_out,
    output reg        burnout_enable_out,
    output reg        force_unity_gain_out,
    output reg        mux_open_out,
    output reg        temp_amp_fault_out,
    output reg  [4:0] cal_samples_out
);

    reg [4:0] samples_d;

    // ======================================================================
    // Sample count lookup
    always @* begin
        case (calibration_average_count_in)
            2'h0:    samples_d = 5'h01;
            2'h1:    samples_d = 5'h04;
            2'h2:    samples_d = 5'h08;
            2'h3:    samples_d = 5'h10;
            default: samples_d = 5'h01;
        endcase
    end

    // ======================================================================
    // Registered decode
    always @(posedge clk_in or negedge reset_n_in) begin
        if (!reset_n_in) begin
            inputs_shorted_mid_out <= 1'b0;
            temp_sensor_out        <= 1'b0;
            avdd_monitor_out       <= 1'b0;
            dvdd_monitor_out       <= 1'b0;
            burnout_level_out      <= 2'h0;
            burnout_enable_out     <= 1'b0;
            force_unity_gain_out   <= 1'b0;
            mux_open_out           <= 1'b0;
            temp_amp_fault_out     <= 1'b0;
            cal_samples_out        <= `BSC_RST_CALCNT;
        end else begin
            inputs_shorted_mid_out <= (monitor_select_in == `BSC_MON_MIDSUP);
            temp_sensor_out        <= (monitor_select_in == `BSC_MON_TEMP);
            avdd_monitor_out       <= (monitor_select_in == `BSC_MON_AVDD);
            dvdd_monitor_out       <= (monitor_select_in == `BSC_MON_DVDD);
            // Burn-out level 0: 0.2 uA, 1: 1 uA, 2: 10 uA
            burnout_enable_out     <= (monitor_select_in >= `BSC_MON_BO_0U2);
            burnout_level_out      <= (monitor_select_in >= `BSC_MON_BO_0U2) ?
                                      (monitor_select_in[1:0] - 2'h1) : 2'h0;
            force_unity_gain_out   <= (monitor_select_in == `BSC_MON_AVDD) ||
                                      (monitor_select_in == `BSC_MON_DVDD);
            mux_open_out           <= (monitor_select_in != `BSC_MON_OFF) &&
                                      (monitor_select_in <= `BSC_MON_DVDD);
            // Software owes the amplifier enable; flag it when missing
            temp_amp_fault_out     <= (monitor_select_in == `BSC_MON_TEMP) &&
                                      (amplifier_enable_field_in != `BSC_AMP_ON);
            cal_samples_out        <= samples_d;
        end
    end

endmodule // bsc_mon_decode

//--- verilog/bsc_top.v
// Purpose: Bias routing and system monitor configuration over AXI4-Lite
// Assumes: Single clock, asynchronous active-low reset
// Notes:   Unmapped addresses answer SLVERR, read as zero
//
// Register access over AXI4-Lite was chosen for this implementation.
`timescale 1ns/1ps
`include "bsc_defines.vh"

module bsc_top (
    input  wire                   CLOCK_IN,
    input  wire                   RESET_N_IN,
    input  wire [`BSC_ADDR_W-1:0] S_AXI_AWADDR_IN,
    input  wire [2:0]             S_AXI_AWPROT_IN,
    input  wire                   S_AXI_AWVALID_IN,
    output wire                   S_AXI_AWREADY_OUT,
    input  wire [31:0]            S_AXI_WDATA_IN,
    input  wire [3:0]             S_AXI_WSTRB_IN,
    input  wire                   S_AXI_WVALID_IN,
    output wire                   S_AXI_WREADY_OUT,
    output reg  [1:0]             S_AXI_BRESP_OUT,
    output reg                    S_AXI_BVALID_OUT,
    input  wire                   S_AXI_BREADY_IN,
    input  wire [`BSC_ADDR_W-1:0] S_AXI_ARADDR_IN,
    input  wire [2:0]             S_AXI_ARPROT_IN,
    input  wire                   S_AXI_ARVALID_IN,
    output wire                   S_AXI_ARREADY_OUT,
    output reg  [31:0]            S_AXI_RDATA_OUT,
    output reg  [1:0]             S_AXI_RRESP_OUT,
    output reg                    S_AXI_RVALID_OUT,
    input  wire                   S_AXI_RREADY_IN,
    input  wire [1:0]             AMPLIFIER_ENABLE_FIELD_IN,
    output reg                    BIAS_ENABLE_OUT,
    output reg                    BIAS_LEVEL_SELECT_OUT,
    output reg                    BIAS_TO_COMMON_INPUT_OUT,
    output reg  [5:0]             BIAS_TO_INPUT_OUT,
    output wire                   INPUTS_SHORTED_MID_OUT,
    output wire                   TEMP_SENSOR_OUT,
    output wire                   AVDD_MONITOR_OUT,
    output wire                   DVDD_MONITOR_OUT,
    output wire                   BURNOUT_ENABLE_OUT,
    output wire [1:0]             BURNOUT_LEVEL_OUT,
    output wire                   FORCE_UNITY_GAIN_OUT,
    output wire                   MUX_OPEN_OUT,
    output wire [4:0]             CAL_SAMPLES_OUT,
    output reg                    SPI_TIMEOUT_ENABLE_OUT,
    output reg                    CHECK_BYTE_APPEND_OUT,
    output reg                    STATUS_BYTE_PREPEND_OUT
);

    // ======================================================================
    // Register storage
    reg  [7:0]             bias_q;
    reg  [7:0]             sysctl_q;
    reg                    aw_held_q;
    reg  [`BSC_ADDR_W-1:0] aw_addr_q;
    reg                    w_held_q;
    reg  [31:0]            w_data_q;
    reg  [3:0]             w_strb_q;
    reg  [7:0]             rd_byte_d;
    reg                    rd_hit_d;
    wire                   temp_amp_fault;

    // ======================================================================
    // Write channel: address and data latched in either order
    assign S_AXI_AWREADY_OUT = !aw_held_q && !S_AXI_BVALID_OUT;
    assign S_AXI_WREADY_OUT  = !w_held_q && !S_AXI_BVALID_OUT;

    wire [7:0] wr_idx = aw_addr_q[9:2];
    wire       wr_go  = aw_held_q && w_held_q;
    wire       wr_hit = (aw_addr_q[1:0] == 2'h0) && (aw_addr_q[`BSC_ADDR_W-1:10] == 2'h0) &&
                        ((wr_idx == `BSC_IDX_BIAS) || (wr_idx == `BSC_IDX_SYSCTL));

    always @(posedge CLOCK_IN or negedge RESET_N_IN) begin
        if (!RESET_N_IN) begin
            aw_held_q        <= 1'b0;
            aw_addr_q        <= {`BSC_ADDR_W{1'b0}};
            w_held_q         <= 1'b0;
            w_data_q         <= 32'h0000_0000;
            w_strb_q         <= 4'h0;
            S_AXI_BVALID_OUT <= 1'b0;
            S_AXI_BRESP_OUT  <= `BSC_RESP_OKAY;
            bias_q           <= `BSC_RST_BIAS;
            sysctl_q         <= `BSC_RST_SYSCTL;
        end else begin
            if (S_AXI_AWVALID_IN && S_AXI_AWREADY_OUT) begin
                aw_held_q <= 1'b1;
                aw_addr_q <= S_AXI_AWADDR_IN;
            end
            if (S_AXI_WVALID_IN && S_AXI_WREADY_OUT) begin
                w_held_q <= 1'b1;
                w_data_q <= S_AXI_WDATA_IN;
                w_strb_q <= S_AXI_WSTRB_IN;
            end
            if (wr_go) begin
                aw_held_q        <= 1'b0;
                w_held_q         <= 1'b0;
                S_AXI_BVALID_OUT <= 1'b1;
                S_AXI_BRESP_OUT  <= wr_hit ? `BSC_RESP_OKAY : `BSC_RESP_SLVERR;
                // Only lane 0 carries register bits; other lanes are ignored
                if (wr_hit && w_strb_q[0]) begin
                    if (wr_idx == `BSC_IDX_BIAS)
                        bias_q <= w_data_q[7:0];
                    else
                        sysctl_q <= w_data_q[7:0];
                end
            end else if (S_AXI_BVALID_OUT && S_AXI_BREADY_IN) begin
                S_AXI_BVALID_OUT <= 1'b0;
            end
        end
    end

    // ======================================================================
    // Read channel
    assign S_AXI_ARREADY_OUT = !S_AXI_RVALID_OUT;
    wire [7:0] rd_idx = S_AXI_ARADDR_IN[9:2];

    always @* begin
        rd_byte_d = 8'h00;
        rd_hit_d  = (S_AXI_ARADDR_IN[1:0] == 2'h0) &&
                    (S_AXI_ARADDR_IN[`BSC_ADDR_W-1:10] == 2'h0);
        case (rd_idx)
            `BSC_IDX_BIAS:   rd_byte_d = bias_q;
            `BSC_IDX_SYSCTL: rd_byte_d = sysctl_q;
            `BSC_IDX_STATUS: rd_byte_d = {7'h00, temp_amp_fault};
            default:         rd_hit_d  = 1'b0;
        endcase
        if (!rd_hit_d)
            rd_byte_d = 8'h00;
    end

    always @(posedge CLOCK_IN or negedge RESET_N_IN) begin
        if (!RESET_N_IN) begin
            S_AXI_RVALID_OUT <= 1'b0;
            S_AXI_RDATA_OUT  <= 32'h0000_0000;
            S_AXI_RRESP_OUT  <= `BSC_RESP_OKAY;
        end else if (S_AXI_ARVALID_IN && S_AXI_ARREADY_OUT) begin
            S_AXI_RVALID_OUT <= 1'b1;
            S_AXI_RDATA_OUT  <= {24'h000000, rd_byte_d};
            S_AXI_RRESP_OUT  <= rd_hit_d ? `BSC_RESP_OKAY : `BSC_RESP_SLVERR;
        end else if (S_AXI_RVALID_OUT && S_AXI_RREADY_IN) begin
            S_AXI_RVALID_OUT <= 1'b0;
        end
    end

    // ======================================================================
    // Bias routing outputs
    wire [5:0] in_sel  = bias_q[`BSC_BIAS_IN_HI:`BSC_BIAS_IN_LO];
    wire       com_sel = bias_q[`BSC_BIAS_COM_BIT];

    always @(posedge CLOCK_IN or negedge RESET_N_IN) begin
        if (!RESET_N_IN) begin
            BIAS_ENABLE_OUT          <= 1'b0;
            BIAS_LEVEL_SELECT_OUT    <= 1'b0;
            BIAS_TO_COMMON_INPUT_OUT <= 1'b0;
            BIAS_TO_INPUT_OUT        <= 6'h00;
        end else begin
            // Unused generator is powered down to save supply current
            BIAS_ENABLE_OUT          <= com_sel || (|in_sel);
            BIAS_LEVEL_SELECT_OUT    <= bias_q[`BSC_BIAS_LEVEL_BIT];
            BIAS_TO_COMMON_INPUT_OUT <= com_sel;
            BIAS_TO_INPUT_OUT        <= in_sel;
        end
    end

    // ======================================================================
    // System control outputs
    always @(posedge CLOCK_IN or negedge RESET_N_IN) begin
        if (!RESET_N_IN) begin
            SPI_TIMEOUT_ENABLE_OUT  <= 1'b0;
            CHECK_BYTE_APPEND_OUT   <= 1'b0;
            STATUS_BYTE_PREPEND_OUT <= 1'b0;
        end else begin
            SPI_TIMEOUT_ENABLE_OUT  <= sysctl_q[`BSC_TMO_BIT];
            CHECK_BYTE_APPEND_OUT   <= sysctl_q[`BSC_CRC_BIT];
            STATUS_BYTE_PREPEND_OUT <= sysctl_q[`BSC_STAT_BIT];
        end
    end

    // ======================================================================
    // Monitor decode; reset value of the field gives code 000 and count 10
    bsc_mon_decode u_mon (
        .clk_in                       (CLOCK_IN),
        .reset_n_in                   (RESET_N_IN),
        .monitor_select_in            (sysctl_q[`BSC_MON_HI:`BSC_MON_LO]),
        .calibration_average_count_in (sysctl_q[`BSC_CAL_HI:`BSC_CAL_LO]),
        .amplifier_enable_field_in    (AMPLIFIER_ENABLE_FIELD_IN),
        .inputs_shorted_mid_out       (INPUTS_SHORTED_MID_OUT),
        .temp_sensor_out              (TEMP_SENSOR_OUT),
        .avdd_monitor_out             (AVDD_MONITOR_OUT),
        .dvdd_monitor_out             (DVDD_MONITOR_OUT),
        .burnout_level_out            (BURNOUT_LEVEL_OUT),
        .burnout_enable_out           (BURNOUT_ENABLE_OUT),
        .force_unity_gain_out         (FORCE_UNITY_GAIN_OUT),
        .mux_open_out                 (MUX_OPEN_OUT),
        .temp_amp_fault_out           (temp_amp_fault),
        .cal_samples_out              (CAL_SAMPLES_OUT)
    );

endmodule // bsc_top
